// ===== encoder_pwm_io_pkg.sv
package encoder_pwm_io_pkg;
	// word offsets on the 16-bit i/o window
	localparam logic [7:0] OFS_COUNT_1 = 8'h00;
	localparam logic [7:0] OFS_COUNT_2 = 8'h02;
	localparam logic [7:0] OFS_COUNT_3 = 8'h04;
	localparam logic [7:0] OFS_INDEX_1 = 8'h06;
	localparam logic [7:0] OFS_INDEX_2 = 8'h08;
	localparam logic [7:0] OFS_INDEX_3 = 8'h0A;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_ISO_OUT = 8'h10;
	localparam logic [7:0] OFS_MODE = 8'h12;
	localparam logic [7:0] OFS_FAST_PERIOD = 8'h16;
	localparam logic [7:0] OFS_SLOW_DEAD = 8'h18;
	localparam logic [7:0] OFS_PWM_U = 8'h1A;
	localparam logic [7:0] OFS_PWM_V = 8'h1C;
	localparam logic [7:0] OFS_PWM_W = 8'h1E;
	localparam logic [7:0] OFS_ISO_IN = 8'h40;
	localparam logic [7:0] OFS_FAST_CLR = 8'h80;
	localparam logic [7:0] OFS_SLOW_CLR = 8'h90;

	// mode_control field positions
	localparam int MODE_CTR1_POS = 0;
	localparam int MODE_CTR2_LO_POS = 1;
	localparam int MODE_CTR2_HI_POS = 2;
	localparam int MODE_FILT_LO_POS = 3;
	localparam int MODE_FILT_HI_POS = 4;
	localparam int MODE_INDEX_POS = 5;
	localparam int MODE_PWM_EN_POS = 7;

	// status_flags field positions
	localparam int STAT_AUX_POS = 0;
	localparam int STAT_ONE_LO_POS = 3;
	localparam int STAT_INDEX_LATCHED_FLAG_3_POS = 4;
	localparam int STAT_INDEX_LATCHED_FLAG_2_POS = 5;
	localparam int STAT_INDEX_LATCHED_FLAG_1_POS = 6;
	localparam int STAT_ONE_HI_POS = 7;
	localparam int STAT_DIR_POS = 8;

	// counter 2 modes
	typedef enum logic [1:0] {
		CTR2_PULSE_DIR = 2'h0,
		CTR2_UP_DOWN = 2'h1,
		CTR2_QUAD_RAW = 2'h2,
		CTR2_QUAD_FILT = 2'h3
	} ctr2_mode_t;

	// values after reset
	localparam logic RST_CTR1_MODE = 1'b1;
	localparam logic [1:0] RST_CTR2_MODE = 2'h3;
	localparam logic [1:0] RST_FILT_BASE = 2'h0;
	localparam logic RST_PWM_EN = 1'b0;
	localparam logic RST_DIR3 = 1'b1;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_BASE_NS = 100;
	localparam int TICK_DIV_CYC = (TICK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT0_NS = 300;
	localparam int FILT1_NS = 600;
	localparam int FILT2_NS = 1200;
	localparam int FILT3_NS = 4800;
	localparam logic [8:0] FILT0_CYC = 9'((FILT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [8:0] FILT1_CYC = 9'((FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [8:0] FILT2_CYC = 9'((FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [8:0] FILT3_CYC = 9'((FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DEAD_UNIT_NS = 750;
	localparam logic [14:0] DEAD_UNIT_CYC = 15'((DEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== encoder_pwm_io_regs.sv
`timescale 1ns/1ps
// How it works
// RULE1 - three read-only 16-bit up/down counters at 0x0, 0x2, 0x4
// RULE2 - index rising edge copies counter into index register and sets latched flag
// RULE3 - any write to an index register offset clears that channel's flag
// RULE4 - status low byte: aux inputs 2..0, ones at 7 and 3, flags 6..4
// RULE5 - flags zero after reset, set on index rising edge, held until cleared
// RULE6 - status high byte zero except bit 0, counter 3 direction, 1 is up
// RULE7 - low byte written at 0x10 drives the eight isolated outputs
// RULE8 - write-only control at 0x12 holds modes, filter base, index option, pwm enable
// RULE9 - counter 1 mode 0 is up/down pulses, 1 (default) quadrature
// RULE10 - counter 2 modes: pulse/dir, up/down, raw quadrature, filtered quadrature
// RULE11 - filter time base 300 ns, 600 ns, 1.2 us or 4.8 us
// RULE12 - filters drop level changes shorter than the selected period
// RULE13 - pwm enable 1 runs six outputs, 0 (default) holds them low
// RULE14 - 16-bit value at 0x16 sets the fast tick period
// RULE15 - word at 0x18 holds slow tick multiplier and dead time value
// RULE16 - three 12-bit pwm settings at 0x1A, 0x1C, 0x1E
// RULE17 - read at 0x40 returns the eight isolated inputs in the low byte
// RULE18 - writes at 0x80 and 0x90 clear the two tick flags; held until cleared
// RULE19 - fast tick counts a 10 MHz base, period 0.1 us times value
// RULE20 - slow tick fires once every n+1 fast tick periods
// RULE21 - dead time between each complementary pair is 0.75 us times m+1
// RULE22 - new pwm setting takes effect from the next fast tick period
// RULE23 - don't-care bits ignored and read zero; counters wrap modulo 65536
// RULE24 - interrupt request is the OR of the two pending tick flags
module encoder_pwm_io_regs #(
	parameter int TICK_DIV = encoder_pwm_io_pkg::TICK_DIV_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	output logic io_rvalid_o,
	input wire logic [2:0] enc_a_in_i,
	input wire logic [2:0] enc_b_in_i,
	input wire logic [2:0] index_pulse_i,
	input wire logic [2:0] aux_input_i,
	input wire logic [7:0] iso_input_bits_i,
	output logic [7:0] iso_output_bits_o,
	output logic phase_u_high_o,
	output logic phase_u_low_o,
	output logic phase_v_high_o,
	output logic phase_v_low_o,
	output logic phase_w_high_o,
	output logic phase_w_low_o,
	output logic int_req_o
);
	import encoder_pwm_io_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// elaboration check: the prescaler needs at least one cycle
	generate
		if (TICK_DIV < 1 || TICK_DIV > 15) begin : g_bad_div
			$error("TICK_DIV must be 1 to 15");
		end
	endgenerate

	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

	////////////////////////////////////////////////////////////////////////////
	// all state of the block
	typedef struct packed {
		logic [2:0][15:0] cnt;
		logic [2:0][15:0] idx;
		logic [2:0] idl;
		logic dir3;
		logic [2:0] a_flt;
		logic [2:0] b_flt;
		logic [2:0][8:0] a_stab;
		logic [2:0][8:0] b_stab;
		logic [2:0] a_prev;
		logic [2:0] b_prev;
		logic [2:0] idx_prev;
		logic [7:0] dout;
		logic ctr1_mode_sel;
		logic [1:0] ctr2_mode;
		logic [1:0] filter_base;
		logic index_opt;
		logic pwm_output_enable;
		logic [15:0] tick_count_value;
		logic [7:0] slow_tick_multiplier;
		logic [7:0] dead_time_value;
		logic [2:0][11:0] pwm_set;
		logic [2:0][11:0] pwm_act;
		logic [3:0] pre;
		logic [15:0] tick_pos;
		logic [7:0] slow_cnt;
		logic fast_tick_irq;
		logic slow_tick_irq;
		logic irq;
		logic [2:0] raw;
		logic [2:0][14:0] dcnt;
		logic [2:0] hi;
		logic [2:0] lo;
		logic [15:0] rdata;
		logic rvalid;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// filter hold time for the selected base
	function automatic logic [8:0] filt_limit(input logic [1:0] sel);
		logic [8:0] lim;
		lim = FILT0_CYC;
		case (sel)
			2'h0: lim = FILT0_CYC;
			2'h1: lim = FILT1_CYC;
			2'h2: lim = FILT2_CYC;
			default: lim = FILT3_CYC;
		endcase
		return lim;
	endfunction

	// quadrature step: {moved, up}; A leading B counts up
	function automatic logic [1:0] quad_step(input logic pa, input logic pb, input logic a, input logic b);
		logic moved;
		moved = (pa ^ a) ^ (pb ^ b);
		return {moved, ~(pa ^ b)};
	endfunction

	// dead time in clock cycles for setting m
	function automatic logic [14:0] dead_cycles(input logic [7:0] m);
		return DEAD_UNIT_CYC * (15'(m) + 15'h0001);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [8:0] lim;
		logic [2:0] dec_a;
		logic [2:0] dec_b;
		logic [2:0] step;
		logic [2:0] up;
		logic [1:0] qs;
		logic fast_evt;
		logic [2:0] idx_clr;
		logic [2:0] idx_set;
		logic rise_a;
		logic rise_b;
		lim = 9'h000;
		dec_a = 3'h0;
		dec_b = 3'h0;
		step = 3'h0;
		up = 3'h0;
		qs = 2'h0;
		fast_evt = 1'b0;
		idx_clr = 3'h0;
		idx_set = 3'h0;
		rise_a = 1'b0;
		rise_b = 1'b0;
		nxt_state = state_ff;

		// RULE11 time base
		lim = filt_limit(state_ff.filter_base);
		// RULE12 glitch rejection: a new level must hold lim cycles without a break
		for (int i = 0; i < 3; i++) begin
			if (enc_a_in_i[i] == state_ff.a_flt[i]) begin
				nxt_state.a_stab[i] = 9'h000;
			end else if (state_ff.a_stab[i] + 9'h001 >= lim) begin
				nxt_state.a_flt[i] = enc_a_in_i[i];
				nxt_state.a_stab[i] = 9'h000;
			end else begin
				nxt_state.a_stab[i] = state_ff.a_stab[i] + 9'h001;
			end
			if (enc_b_in_i[i] == state_ff.b_flt[i]) begin
				nxt_state.b_stab[i] = 9'h000;
			end else if (state_ff.b_stab[i] + 9'h001 >= lim) begin
				nxt_state.b_flt[i] = enc_b_in_i[i];
				nxt_state.b_stab[i] = 9'h000;
			end else begin
				nxt_state.b_stab[i] = state_ff.b_stab[i] + 9'h001;
			end
		end

		// decoder inputs; only counter 2 raw quadrature skips the filter
		dec_a = nxt_state.a_flt;
		dec_b = nxt_state.b_flt;
		// RULE10 filter bypass
		if (ctr2_mode_t'(state_ff.ctr2_mode) == CTR2_QUAD_RAW) begin
			dec_a[1] = enc_a_in_i[1];
			dec_b[1] = enc_b_in_i[1];
		end
		nxt_state.a_prev = dec_a;
		nxt_state.b_prev = dec_b;

		// per-channel count decision
		for (int i = 0; i < 3; i++) begin
			qs = quad_step(state_ff.a_prev[i], state_ff.b_prev[i], dec_a[i], dec_b[i]);
			rise_a = dec_a[i] & ~state_ff.a_prev[i];
			rise_b = dec_b[i] & ~state_ff.b_prev[i];
			step[i] = qs[1];
			up[i] = qs[0];
			if (i == 0) begin
				// RULE9 counter 1 mode
				if (!state_ff.ctr1_mode_sel) begin
					step[i] = rise_a ^ rise_b;
					up[i] = rise_a;
				end
			end else if (i == 1) begin
				// RULE10 counter 2 modes
				case (ctr2_mode_t'(state_ff.ctr2_mode))
					CTR2_PULSE_DIR: begin
						step[i] = rise_a;
						up[i] = ~dec_b[i];
					end
					CTR2_UP_DOWN: begin
						step[i] = rise_a ^ rise_b;
						up[i] = rise_a;
					end
					default: begin
						step[i] = qs[1];
						up[i] = qs[0];
					end
				endcase
			end
			// RULE1 RULE23 up/down count, wraps
			if (step[i]) begin
				nxt_state.cnt[i] = up[i] ? state_ff.cnt[i] + 16'h0001 : state_ff.cnt[i] - 16'h0001;
			end
		end
		// RULE6 direction of counter 3
		if (step[2]) begin
			nxt_state.dir3 = up[2];
		end

		// RULE2 RULE5 index capture on rising edge
		nxt_state.idx_prev = index_pulse_i;
		idx_set = index_pulse_i & ~state_ff.idx_prev;
		for (int i = 0; i < 3; i++) begin
			if (idx_set[i]) begin
				nxt_state.idx[i] = state_ff.cnt[i];
			end
		end

		// register writes; data ignored on strobe offsets
		if (io_wr_i) begin
			case (io_addr_i)
				// RULE3 flag clear strobes
				OFS_INDEX_1: idx_clr[0] = 1'b1;
				OFS_INDEX_2: idx_clr[1] = 1'b1;
				OFS_INDEX_3: idx_clr[2] = 1'b1;
				// RULE7 RULE23 output latch, high byte dropped
				OFS_ISO_OUT: nxt_state.dout = io_wdata_i[7:0];
				// RULE8 control fields
				OFS_MODE: begin
					nxt_state.ctr1_mode_sel = io_wdata_i[MODE_CTR1_POS];
					nxt_state.ctr2_mode = {io_wdata_i[MODE_CTR2_HI_POS], io_wdata_i[MODE_CTR2_LO_POS]};
					nxt_state.filter_base = {io_wdata_i[MODE_FILT_HI_POS], io_wdata_i[MODE_FILT_LO_POS]};
					nxt_state.index_opt = io_wdata_i[MODE_INDEX_POS];
					nxt_state.pwm_output_enable = io_wdata_i[MODE_PWM_EN_POS];
				end
				// RULE14 fast tick period
				OFS_FAST_PERIOD: nxt_state.tick_count_value = io_wdata_i;
				// RULE15 dead time low byte, multiplier high byte
				OFS_SLOW_DEAD: begin
					nxt_state.dead_time_value = io_wdata_i[7:0];
					nxt_state.slow_tick_multiplier = io_wdata_i[15:8];
				end
				// RULE16 12-bit settings, upper nibble dropped
				OFS_PWM_U: nxt_state.pwm_set[0] = io_wdata_i[11:0];
				OFS_PWM_V: nxt_state.pwm_set[1] = io_wdata_i[11:0];
				OFS_PWM_W: nxt_state.pwm_set[2] = io_wdata_i[11:0];
				// RULE18 tick flag clears
				OFS_FAST_CLR: nxt_state.fast_tick_irq = 1'b0;
				OFS_SLOW_CLR: nxt_state.slow_tick_irq = 1'b0;
				default: nxt_state.dout = state_ff.dout;
			endcase
		end
		// RULE5 a new edge beats a clear in the same cycle
		nxt_state.idl = (state_ff.idl & ~idx_clr) | idx_set;

		// RULE19 10 MHz prescaler and fast tick; period 0 halts it
		if (state_ff.tick_count_value == 16'h0000) begin
			nxt_state.pre = 4'h0;
			nxt_state.tick_pos = 16'h0000;
		end else if (state_ff.pre >= TICK_LAST) begin
			nxt_state.pre = 4'h0;
			if (state_ff.tick_pos + 16'h0001 >= state_ff.tick_count_value) begin
				nxt_state.tick_pos = 16'h0000;
				fast_evt = 1'b1;
			end else begin
				nxt_state.tick_pos = state_ff.tick_pos + 16'h0001;
			end
		end else begin
			nxt_state.pre = state_ff.pre + 4'h1;
		end

		if (fast_evt) begin
			// RULE22 settings adopted only at a period boundary
			nxt_state.pwm_act = state_ff.pwm_set;
			// RULE18 set wins over a same-cycle clear
			nxt_state.fast_tick_irq = 1'b1;
			// RULE20 slow tick every n+1 fast periods
			if (state_ff.slow_cnt >= state_ff.slow_tick_multiplier) begin
				nxt_state.slow_cnt = 8'h00;
				nxt_state.slow_tick_irq = 1'b1;
			end else begin
				nxt_state.slow_cnt = state_ff.slow_cnt + 8'h01;
			end
		end
		// RULE24 one request line
		nxt_state.irq = nxt_state.fast_tick_irq | nxt_state.slow_tick_irq;

		// pwm with dead time; each edge of the raw wave blanks both outputs
		for (int i = 0; i < 3; i++) begin
			// RULE13 enable gates the raw wave
			nxt_state.raw[i] = state_ff.pwm_output_enable && (state_ff.tick_pos < 16'(state_ff.pwm_act[i]));
			if (nxt_state.raw[i] != state_ff.raw[i]) begin
				// RULE21 blanking length
				nxt_state.dcnt[i] = dead_cycles(state_ff.dead_time_value);
				nxt_state.hi[i] = 1'b0;
				nxt_state.lo[i] = 1'b0;
			end else if (state_ff.dcnt[i] != 15'h0000) begin
				nxt_state.dcnt[i] = state_ff.dcnt[i] - 15'h0001;
				nxt_state.hi[i] = 1'b0;
				nxt_state.lo[i] = 1'b0;
			end else begin
				// RULE13 both low while disabled
				nxt_state.hi[i] = state_ff.raw[i];
				nxt_state.lo[i] = ~state_ff.raw[i] & state_ff.pwm_output_enable;
			end
		end

		// read port: data one cycle after the strobe, unmapped and write-only read zero
		nxt_state.rvalid = io_rd_i;
		nxt_state.rdata = 16'h0000;
		if (io_rd_i) begin
			case (io_addr_i)
				// RULE1 counter words
				OFS_COUNT_1: nxt_state.rdata = state_ff.cnt[0];
				OFS_COUNT_2: nxt_state.rdata = state_ff.cnt[1];
				OFS_COUNT_3: nxt_state.rdata = state_ff.cnt[2];
				// RULE2 index words
				OFS_INDEX_1: nxt_state.rdata = state_ff.idx[0];
				OFS_INDEX_2: nxt_state.rdata = state_ff.idx[1];
				OFS_INDEX_3: nxt_state.rdata = state_ff.idx[2];
				OFS_STATUS: begin
					// RULE4 status low byte
					nxt_state.rdata[STAT_AUX_POS +: 3] = aux_input_i;
					nxt_state.rdata[STAT_ONE_LO_POS] = 1'b1;
					nxt_state.rdata[STAT_INDEX_LATCHED_FLAG_3_POS] = state_ff.idl[2];
					nxt_state.rdata[STAT_INDEX_LATCHED_FLAG_2_POS] = state_ff.idl[1];
					nxt_state.rdata[STAT_INDEX_LATCHED_FLAG_1_POS] = state_ff.idl[0];
					nxt_state.rdata[STAT_ONE_HI_POS] = 1'b1;
					// RULE6 direction bit, rest of high byte zero
					nxt_state.rdata[STAT_DIR_POS] = state_ff.dir3;
				end
				// RULE17 RULE23 isolated inputs, high byte zero
				OFS_ISO_IN: nxt_state.rdata = {8'h00, iso_input_bits_i};
				default: nxt_state.rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; only constants under reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= '0;
			state_ff.ctr1_mode_sel <= RST_CTR1_MODE;
			state_ff.ctr2_mode <= RST_CTR2_MODE;
			state_ff.filter_base <= RST_FILT_BASE;
			state_ff.pwm_output_enable <= RST_PWM_EN;
			state_ff.dir3 <= RST_DIR3;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs taken straight from the state flops
	assign io_rdata_o = state_ff.rdata;
	assign io_rvalid_o = state_ff.rvalid;
	assign iso_output_bits_o = state_ff.dout;
	assign phase_u_high_o = state_ff.hi[0];
	assign phase_u_low_o = state_ff.lo[0];
	assign phase_v_high_o = state_ff.hi[1];
	assign phase_v_low_o = state_ff.lo[1];
	assign phase_w_high_o = state_ff.hi[2];
	assign phase_w_low_o = state_ff.lo[2];
	assign int_req_o = state_ff.irq;

endmodule

// ===== encoder_pwm_io_assertions.sv
`timescale 1ns/1ps
module encoder_pwm_io_checker
	import encoder_pwm_io_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic io_rvalid_o,
	input wire logic [7:0] iso_input_bits_i,
	input wire logic [7:0] iso_output_bits_o,
	input wire logic phase_u_high_o,
	input wire logic phase_u_low_o,
	input wire logic phase_v_high_o,
	input wire logic phase_v_low_o,
	input wire logic phase_w_high_o,
	input wire logic phase_w_low_o,
	input wire logic int_req_o
);
	// one clock domain, so one default for all properties
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	property p_rd_answer; io_rd_i |=> io_rvalid_o; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_idle_zero; !io_rvalid_o |-> io_rdata_o == 16'h0000; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
	property p_status_fixed;
		io_rd_i && io_addr_i == OFS_STATUS |=> io_rdata_o[7] && io_rdata_o[3] && io_rdata_o[15:9] == 7'h00;
	endproperty
	a_status_fixed: assert property (p_status_fixed) else $error("status fixed bits wrong");
	property p_iso_in; io_rd_i && io_addr_i == OFS_ISO_IN |=> io_rdata_o == {8'h00, $past(iso_input_bits_i)}; endproperty
	a_iso_in: assert property (p_iso_in) else $error("input port read wrong");
	property p_iso_out;
		io_wr_i && io_addr_i == OFS_ISO_OUT |=> {8'h00, iso_output_bits_o} == ($past(io_wdata_i) & 16'h00FF);
	endproperty
	a_iso_out: assert property (p_iso_out) else $error("output latch wrong");
	property p_wo_zero; io_rd_i && io_addr_i == OFS_MODE |=> io_rdata_o == 16'h0000; endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("write-only register read back");
	// a pair driven both high would short the bridge transistors
	property p_pair;
		!(phase_u_high_o && phase_u_low_o) && !(phase_v_high_o && phase_v_low_o) && !(phase_w_high_o && phase_w_low_o);
	endproperty
	a_pair: assert property (p_pair) else $error("complementary pair both high");
	property p_blank; $fell(phase_u_low_o) |-> !phase_u_high_o [*8]; endproperty
	a_blank: assert property (p_blank) else $error("no dead time after low side off");
	property p_irq_hold;
		int_req_o && !(io_wr_i && (io_addr_i == OFS_FAST_CLR || io_addr_i == OFS_SLOW_CLR)) |=> int_req_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");

	// main scenarios reached
	c_read: cover property (io_rvalid_o);
	c_irq: cover property ($rose(int_req_o));
	c_pwm: cover property ($rose(phase_u_high_o));
endmodule

bind encoder_pwm_io_regs encoder_pwm_io_checker checker_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
	.io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .iso_input_bits_i(iso_input_bits_i),
	.iso_output_bits_o(iso_output_bits_o), .phase_u_high_o(phase_u_high_o), .phase_u_low_o(phase_u_low_o),
	.phase_v_high_o(phase_v_high_o), .phase_v_low_o(phase_v_low_o), .phase_w_high_o(phase_w_high_o),
	.phase_w_low_o(phase_w_low_o), .int_req_o(int_req_o));

// ===== io_bridge_model.sv
`timescale 1ns/1ps
module io_bridge_model (
	input wire logic mclk_i,
	input wire logic [15:0] rdata_i,
	input wire logic rvalid_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] wdata_o
);
	// idle bus at time zero
	initial begin
		addr_o = 8'hFF;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// released lines show the inverse so stale values never pass for valid ones
	task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge mclk_i);
		#1;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// answer stands right after the taking edge, sampled 1 ns later
	task automatic rd_word(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(posedge mclk_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge mclk_i);
		#1;
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
		v = rvalid_i;
	endtask
endmodule

// ===== tb_encoder_pwm_io_regs.sv
`timescale 1ns/1ps
module tb_encoder_pwm_io_regs;
	import encoder_pwm_io_pkg::*;
	logic mclk_i;
	logic rst_n_i;
	logic [7:0] io_addr;
	logic io_wr;
	logic io_rd;
	logic [15:0] io_wdata;
	logic [15:0] io_rdata;
	logic io_rvalid;
	logic [2:0] enc_a = 3'h0;
	logic [2:0] enc_b = 3'h0;
	logic [2:0] index_pulse = 3'h0;
	logic [7:0] iso_out;
	logic uh, ul, vh, vl, wh, wl, irq;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;

	// tick divider shortened to 1 so timer periods are counted in clocks
	encoder_pwm_io_regs #(.TICK_DIV(1)) encoder_pwm_io_regs_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
		.io_rvalid_o(io_rvalid), .enc_a_in_i(enc_a), .enc_b_in_i(enc_b), .index_pulse_i(index_pulse),
		.aux_input_i(3'h5), .iso_input_bits_i(8'h3C), .iso_output_bits_o(iso_out), .phase_u_high_o(uh),
		.phase_u_low_o(ul), .phase_v_high_o(vh), .phase_v_low_o(vl), .phase_w_high_o(wh), .phase_w_low_o(wl),
		.int_req_o(irq));
	io_bridge_model io_bridge_model_inst (.mclk_i(mclk_i), .rdata_i(io_rdata), .rvalid_i(io_rvalid),
		.addr_o(io_addr), .wr_o(io_wr), .rd_o(io_rd), .wdata_o(io_wdata));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// a hang costs a mismatch rather than a silent stall
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			$display("MISMATCH t=%0t timeout got=%h exp=%h", $time, cyc, 30000);
			print_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic v;
		io_bridge_model_inst.rd_word(a, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		io_bridge_model_inst.wr_word(a, d);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// hold time w on a phase line, then low for w+40 so the release passes the filter too
	task automatic pulse(input int ch, input bit on_b, input int w);
		if (on_b) enc_b[ch] = 1'b1;
		else enc_a[ch] = 1'b1;
		wait_cyc(w);
		if (on_b) enc_b[ch] = 1'b0;
		else enc_a[ch] = 1'b0;
		wait_cyc(w + 40);
	endtask

	// one full quadrature cycle on the channels in m; A leads for up, B leads when rev
	task automatic quad4(input logic [2:0] m, input bit rev, input int w);
		for (int k = 0; k < 4; k++) begin
			if ((k % 2 == 0) != rev) enc_a = enc_a ^ m;
			else enc_b = enc_b ^ m;
			wait_cyc(w);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(OFS_STATUS, 16'h018D);
		rd_chk(OFS_COUNT_1, 16'h0000);
		rd_chk(8'h14, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_io;
		wr(OFS_ISO_OUT, 16'hFFA5);
		chk({8'h00, iso_out}, 16'h00A5);
		rd_chk(OFS_ISO_IN, 16'h003C);
		rd_chk(OFS_MODE, 16'h0000);
		$display("test io done");
	endtask

	task automatic t_count;
		wr(OFS_MODE, 16'h0000);
		repeat (3) pulse(0, 0, 40);
		pulse(0, 1, 40);
		rd_chk(OFS_COUNT_1, 16'h0002);
		pulse(0, 0, 10);
		rd_chk(OFS_COUNT_1, 16'h0002);
		repeat (3) pulse(0, 1, 40);
		rd_chk(OFS_COUNT_1, 16'hFFFF);
		enc_b[1] = 1'b1;
		repeat (2) pulse(1, 0, 40);
		enc_b[1] = 1'b0;
		rd_chk(OFS_COUNT_2, 16'hFFFE);
		// let B settle low before counter 2 turns quadrature, or its late fall counts
		wait_cyc(40);
		// both counters quadrature through the 120-cycle filter
		wr(OFS_MODE, 16'h0017);
		quad4(3'h3, 1'b0, 130);
		rd_chk(OFS_COUNT_1, 16'h0003);
		rd_chk(OFS_COUNT_2, 16'h0002);
		// raw quadrature on counter 2: 5-cycle steps would never pass the filter
		wr(OFS_MODE, 16'h0005);
		quad4(3'h2, 1'b1, 5);
		rd_chk(OFS_COUNT_2, 16'hFFFE);
		// counter 2 up/down pulses; the 60-cycle base drops the 50-cycle pulse
		wr(OFS_MODE, 16'h000A);
		pulse(1, 0, 70);
		pulse(1, 0, 70);
		pulse(1, 1, 70);
		pulse(1, 0, 50);
		rd_chk(OFS_COUNT_2, 16'hFFFF);
		// 120-cycle base: 100 dropped, 130 counted; 480-cycle base drops 400
		wr(OFS_MODE, 16'h0010);
		pulse(0, 0, 100);
		pulse(0, 0, 130);
		rd_chk(OFS_COUNT_1, 16'h0004);
		wr(OFS_MODE, 16'h0018);
		pulse(0, 0, 400);
		rd_chk(OFS_COUNT_1, 16'h0004);
		$display("test count done");
	endtask

	task automatic t_index;
		index_pulse[0] = 1'b1;
		wait_cyc(5);
		index_pulse[0] = 1'b0;
		rd_chk(OFS_INDEX_1, 16'h0004);
		rd_chk(OFS_STATUS, 16'h01CD);
		wr(OFS_INDEX_1, 16'h1234);
		rd_chk(OFS_STATUS, 16'h018D);
		$display("test index done");
	endtask

	// period 2000 clocks, n=0 so both flags set at each event, m=0
	task automatic t_timer_pwm;
		wr(OFS_SLOW_DEAD, 16'h0000);
		wr(OFS_FAST_PERIOD, 16'h07D0);
		wr(OFS_PWM_U, 16'hFFFF);
		wr(OFS_MODE, 16'h0080);
		wait_cyc(1500);
		chk({15'h0000, irq}, 16'h0000);
		chk({14'h0000, uh, ul}, 16'h0001);
		wait_cyc(700);
		chk({15'h0000, irq}, 16'h0001);
		chk({10'h000, uh, ul, vh, vl, wh, wl}, 16'h0025);
		wr(OFS_FAST_CLR, 16'h0000);
		wait_cyc(2);
		chk({15'h0000, irq}, 16'h0001);
		wr(OFS_SLOW_CLR, 16'h0000);
		wait_cyc(2);
		chk({15'h0000, irq}, 16'h0000);
		// n=1 and a 1000-tick width on v, both adopted at the next period
		wr(OFS_SLOW_DEAD, 16'h0100);
		wr(OFS_PWM_V, 16'hF3E8);
		wait_cyc(2290);
		chk({10'h000, uh, ul, vh, vl, wh, wl}, 16'h0029);
		wr(OFS_FAST_CLR, 16'h0000);
		wait_cyc(2);
		chk({15'h0000, irq}, 16'h0000);
		wait_cyc(1000);
		chk({10'h000, uh, ul, vh, vl, wh, wl}, 16'h0025);
		wr(OFS_MODE, 16'h0000);
		wait_cyc(100);
		chk({10'h000, uh, ul, vh, vl, wh, wl}, 16'h0000);
		$display("test timer and pwm done");
	endtask

	initial begin
		rst_n_i = 1'b0;
		wait_cyc(10);
		rst_n_i = 1'b1;
		t_reset();
		t_io();
		t_count();
		t_index();
		t_timer_pwm();
		print_verdict();
	end
endmodule
